// *** verilog/fpmc_front_panel.sv ***
/*
  Front-panel operating logic of a temperature transducer: three keys,
  display/menu/parameter modes, sensor-input and simulation settings,
  min/max records and the power-on lamp test.
  Assumes measured values arrive in signed tenths of a degree from logic
  on the same clock; digit rendering is done downstream from the outputs.
*/
`timescale 1ns/1ns
module fpmc_front_panel #(
  parameter int unsigned LAMP_CYCLES = 32'(fpmc_pkg::LAMP_CYC),
  parameter int unsigned LONG_CYCLES = 32'(fpmc_pkg::LONG_CYC),
  parameter int unsigned DEBOUNCE_CYCLES = 32'(fpmc_pkg::DEBOUNCE_CYC),
  parameter int unsigned REPEAT_CYCLES = 32'(fpmc_pkg::REPEAT_CYC),
  parameter int unsigned BLINK_CYCLES = 32'(fpmc_pkg::BLINK_CYC),
  parameter logic [39:0] IDLE_CYCLES = 40'(fpmc_pkg::IDLE_CYC),
  parameter logic [39:0] SIM_IDLE_CYCLES = 40'(fpmc_pkg::SIM_IDLE_CYC)
) (
  // Clock, reset, enable
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Keys, active low pins
  input wire logic key_up_n_in,
  input wire logic key_down_n_in,
  input wire logic key_set_n_in,
  // Measurement
  input wire logic signed [14:0] temp_value_in,
  input wire logic temp_valid_in,
  // Display
  output logic lamp_test_out,
  output logic ready_out,
  output logic dp_last_out,
  output logic [1:0] disp_kind_out,
  output logic signed [14:0] disp_value_out,
  output logic disp_tenths_out,
  // Mode and settings
  output logic [1:0] mode_out,
  output logic [1:0] menu_item_out,
  output logic param_index_out,
  output logic [3:0] sensor_type_out,
  output logic [9:0] line_res_out,
  output logic three_wire_out,
  output logic [2:0] sim_select_out,
  output logic signed [14:0] sim_temp_out,
  output logic signed [14:0] min_value_out,
  output logic signed [14:0] max_value_out
);

  typedef struct packed {
    fpmc_pkg::fpmc_mode_type mode;
    fpmc_pkg::fpmc_menu_type item;
    logic pidx;
    logic signed [14:0] edit;
    logic [3:0] sensor;
    logic [9:0] line_res;
    logic [2:0] sim_sel;
    logic signed [14:0] sim_temp;
    logic signed [14:0] live;
    logic signed [14:0] min_val;
    logic signed [14:0] max_val;
    logic have_sample;
    fpmc_pkg::fpmc_show_type show;
    logic [31:0] lamp_cnt;
    logic [39:0] idle_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic dp;
    fpmc_pkg::fpmc_kind_type kind;
    logic signed [14:0] disp_val;
    logic disp_tenths;
  } fpmc_state_type;

  fpmc_state_type s;
  fpmc_state_type next_s;

  logic up_held;
  logic up_press;
  logic up_short;
  logic up_long;
  logic up_rep;
  logic dn_held;
  logic dn_press;
  logic dn_short;
  logic dn_long;
  logic dn_rep;
  logic set_held;
  logic set_short;
  logic set_long;

  fpmc_key #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .LONG_CYCLES(LONG_CYCLES),
    .REPEAT_CYCLES(REPEAT_CYCLES)
  ) u_key_up (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .key_n_in(key_up_n_in),
    .held_out(up_held),
    .press_out(up_press),
    .short_out(up_short),
    .long_out(up_long),
    .repeat_out(up_rep)
  );

  fpmc_key #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .LONG_CYCLES(LONG_CYCLES),
    .REPEAT_CYCLES(REPEAT_CYCLES)
  ) u_key_down (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .key_n_in(key_down_n_in),
    .held_out(dn_held),
    .press_out(dn_press),
    .short_out(dn_short),
    .long_out(dn_long),
    .repeat_out(dn_rep)
  );

  fpmc_key #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .LONG_CYCLES(LONG_CYCLES),
    .REPEAT_CYCLES(REPEAT_CYCLES)
  ) u_key_set (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .key_n_in(key_set_n_in),
    .held_out(set_held),
    .press_out(),
    .short_out(set_short),
    .long_out(set_long),
    .repeat_out()
  );

  // Upper edit limit of a parameter position
  function automatic logic signed [14:0] edit_top(input fpmc_pkg::fpmc_menu_type item,
                                                  input logic pidx);
    if (item == fpmc_pkg::MENU_INPUT)
    begin
      edit_top = pidx ? fpmc_pkg::LINE_3WIRE : fpmc_pkg::SENSOR_LAST;
    end
    else
    begin
      edit_top = pidx ? fpmc_pkg::TEMP_MAX : fpmc_pkg::SIM_SEL_LAST;
    end
  endfunction : edit_top

  function automatic logic signed [14:0] edit_bottom(input fpmc_pkg::fpmc_menu_type item,
                                                     input logic pidx);
    edit_bottom = (item == fpmc_pkg::MENU_SIM && pidx) ? fpmc_pkg::TEMP_MIN : fpmc_pkg::ZERO;
  endfunction : edit_bottom

  // Stored value of a parameter position, loaded into the editor
  function automatic logic signed [14:0] stored(input fpmc_state_type st,
                                                input logic pidx);
    if (st.item == fpmc_pkg::MENU_INPUT)
    begin
      stored = pidx ? 15'(st.line_res) : 15'(st.sensor);
    end
    else
    begin
      stored = pidx ? st.sim_temp : 15'(st.sim_sel);
    end
  endfunction : stored

  function automatic logic fine(input logic signed [14:0] v);
    fine = (v >= fpmc_pkg::FINE_MIN) && (v <= fpmc_pkg::FINE_MAX);
  endfunction : fine

  logic signed [14:0] temp_clamped;
  logic signed [14:0] lo;
  logic signed [14:0] hi;
  logic [39:0] idle_limit;
  logic any_key;
  logic last_param;

  always_comb
  begin
    next_s = s;
    lo = edit_bottom(s.item, s.pidx);
    hi = edit_top(s.item, s.pidx);
    any_key = up_held | dn_held | set_held;
    // Thermocouples end the input item after the sensor type
    last_param = s.pidx || (s.item == fpmc_pkg::MENU_INPUT &&
                 s.edit[3:0] >= fpmc_pkg::RES_TYPES);
    if (s.mode == fpmc_pkg::MODE_PARAM && s.item == fpmc_pkg::MENU_SIM)
    begin
      idle_limit = SIM_IDLE_CYCLES;
    end
    else
    begin
      idle_limit = IDLE_CYCLES;
    end
    if (temp_value_in < fpmc_pkg::TEMP_MIN)
    begin
      temp_clamped = fpmc_pkg::TEMP_MIN;
    end
    else if (temp_value_in > fpmc_pkg::TEMP_MAX)
    begin
      temp_clamped = fpmc_pkg::TEMP_MAX;
    end
    else
    begin
      temp_clamped = temp_value_in;
    end

    if (temp_valid_in && s.mode != fpmc_pkg::MODE_LAMP)
    begin
      next_s.live = temp_clamped;
      next_s.have_sample = 1'b1;
      if (!s.have_sample || temp_clamped < s.min_val)
      begin
        next_s.min_val = temp_clamped;
      end
      if (!s.have_sample || temp_clamped > s.max_val)
      begin
        next_s.max_val = temp_clamped;
      end
    end

    if (s.blink_cnt >= BLINK_CYCLES - 1)
    begin
      next_s.blink_cnt = '0;
      next_s.blink = ~s.blink;
    end
    else
    begin
      next_s.blink_cnt = s.blink_cnt + 32'h0000_0001;
    end

    if (any_key)
    begin
      next_s.idle_cnt = '0;
    end
    else if (s.idle_cnt < idle_limit)
    begin
      next_s.idle_cnt = s.idle_cnt + 40'h00_0000_0001;
    end

    case (s.mode)
      fpmc_pkg::MODE_LAMP:
      begin
        if (s.lamp_cnt >= LAMP_CYCLES - 1)
        begin
          next_s.mode = fpmc_pkg::MODE_DISPLAY;
        end
        else
        begin
          next_s.lamp_cnt = s.lamp_cnt + 32'h0000_0001;
        end
      end
      fpmc_pkg::MODE_DISPLAY:
      begin
        if (up_long)
        begin
          next_s.show = fpmc_pkg::SHOW_MAX;
        end
        else if (dn_long)
        begin
          next_s.show = fpmc_pkg::SHOW_MIN;
        end
        else if (!up_held && !dn_held)
        begin
          next_s.show = fpmc_pkg::SHOW_LIVE;
        end
        if (set_long && s.show == fpmc_pkg::SHOW_MAX)
        begin
          next_s.max_val = s.live;
        end
        else if (set_long && s.show == fpmc_pkg::SHOW_MIN)
        begin
          next_s.min_val = s.live;
        end
        if (s.show == fpmc_pkg::SHOW_LIVE && dn_short)
        begin
          next_s.mode = fpmc_pkg::MODE_MENU;
          next_s.item = fpmc_pkg::MENU_FIRST;
        end
        else if (s.show == fpmc_pkg::SHOW_LIVE && up_short)
        begin
          next_s.mode = fpmc_pkg::MODE_MENU;
          next_s.item = fpmc_pkg::MENU_LAST;
        end
      end
      fpmc_pkg::MODE_MENU:
      begin
        if (set_long || s.idle_cnt >= idle_limit)
        begin
          next_s.mode = fpmc_pkg::MODE_DISPLAY;
        end
        else if (dn_short)
        begin
          if (s.item == fpmc_pkg::MENU_LAST)
          begin
            next_s.mode = fpmc_pkg::MODE_DISPLAY;
          end
          else
          begin
            next_s.item = fpmc_pkg::fpmc_menu_type'(s.item + 2'b01);
          end
        end
        else if (up_short)
        begin
          if (s.item == fpmc_pkg::MENU_FIRST)
          begin
            next_s.mode = fpmc_pkg::MODE_DISPLAY;
          end
          else
          begin
            next_s.item = fpmc_pkg::fpmc_menu_type'(s.item - 2'b01);
          end
        end
        else if (set_short)
        begin
          next_s.mode = fpmc_pkg::MODE_PARAM;
          next_s.pidx = 1'b0;
          next_s.edit = stored(s, 1'b0);
        end
      end
      fpmc_pkg::MODE_PARAM:
      begin
        if (up_held && dn_held && (up_press || dn_press))
        begin
          next_s.edit = fpmc_pkg::ZERO;
        end
        else if ((up_press || up_rep) && !dn_held && s.edit < hi)
        begin
          next_s.edit = s.edit + 15'sh0001;
        end
        else if ((dn_press || dn_rep) && !up_held && s.edit > lo)
        begin
          next_s.edit = s.edit - 15'sh0001;
        end
        // Store on short Set, or on long Set outside simulation
        if (set_short || (set_long && s.item != fpmc_pkg::MENU_SIM))
        begin
          if (s.item == fpmc_pkg::MENU_INPUT && !s.pidx)
          begin
            next_s.sensor = s.edit[3:0];
          end
          else if (s.item == fpmc_pkg::MENU_INPUT)
          begin
            next_s.line_res = s.edit[9:0];
          end
          else if (!s.pidx)
          begin
            next_s.sim_sel = s.edit[2:0];
          end
          else
          begin
            next_s.sim_temp = s.edit;
          end
        end
        if (set_long && s.item != fpmc_pkg::MENU_SIM)
        begin
          next_s.mode = fpmc_pkg::MODE_DISPLAY;
        end
        else if (s.idle_cnt >= idle_limit)
        begin
          next_s.mode = fpmc_pkg::MODE_DISPLAY;
        end
        else if (set_short && last_param)
        begin
          next_s.mode = fpmc_pkg::MODE_MENU;
        end
        else if (set_short)
        begin
          next_s.pidx = 1'b1;
          next_s.edit = stored(s, 1'b1);
        end
      end
      default:
      begin
        next_s.mode = fpmc_pkg::MODE_DISPLAY;
      end
    endcase

    // Registered display picture, derived from the next state
    next_s.disp_tenths = 1'b0;
    case (next_s.mode)
      fpmc_pkg::MODE_LAMP:
      begin
        next_s.dp = 1'b1;
        next_s.kind = fpmc_pkg::KIND_LAMP;
        next_s.disp_val = fpmc_pkg::ZERO;
      end
      fpmc_pkg::MODE_DISPLAY:
      begin
        next_s.dp = 1'b0;
        next_s.kind = fpmc_pkg::KIND_VALUE;
        if (next_s.show == fpmc_pkg::SHOW_MAX)
        begin
          next_s.disp_val = next_s.max_val;
        end
        else if (next_s.show == fpmc_pkg::SHOW_MIN)
        begin
          next_s.disp_val = next_s.min_val;
        end
        else
        begin
          next_s.disp_val = next_s.live;
        end
        next_s.disp_tenths = fine(next_s.disp_val);
        if (!next_s.disp_tenths)
        begin
          next_s.disp_val = next_s.disp_val / fpmc_pkg::TENTHS_DIV;
        end
      end
      fpmc_pkg::MODE_MENU:
      begin
        next_s.dp = 1'b1;
        next_s.kind = fpmc_pkg::KIND_MENU;
        next_s.disp_val = 15'(next_s.item);
      end
      default:
      begin
        next_s.dp = next_s.blink;
        next_s.kind = fpmc_pkg::KIND_PARAM;
        next_s.disp_val = next_s.edit;
        if (next_s.item == fpmc_pkg::MENU_INPUT && next_s.pidx)
        begin
          next_s.disp_tenths = next_s.edit != fpmc_pkg::LINE_3WIRE;
        end
        else if (next_s.item == fpmc_pkg::MENU_SIM && next_s.pidx)
        begin
          next_s.disp_tenths = fine(next_s.edit);
          if (!next_s.disp_tenths)
          begin
            next_s.disp_val = next_s.edit / fpmc_pkg::TENTHS_DIV;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s <= '0;
      s.mode <= fpmc_pkg::MODE_LAMP;
      s.line_res <= fpmc_pkg::LINE_3WIRE_U;
      s.dp <= 1'b1;
    end
    else if (clk_en_in)
    begin
      s <= next_s;
    end
  end

  assign lamp_test_out = s.mode == fpmc_pkg::MODE_LAMP;
  assign ready_out = s.mode != fpmc_pkg::MODE_LAMP;
  assign dp_last_out = s.dp;
  assign disp_kind_out = s.kind;
  assign disp_value_out = s.disp_val;
  assign disp_tenths_out = s.disp_tenths;
  assign mode_out = s.mode;
  assign menu_item_out = s.item;
  assign param_index_out = s.pidx;
  assign sensor_type_out = s.sensor;
  assign line_res_out = s.line_res;
  assign three_wire_out = s.line_res == fpmc_pkg::LINE_3WIRE_U;
  assign sim_select_out = s.sim_sel;
  assign sim_temp_out = s.sim_temp;
  assign min_value_out = s.min_val;
  assign max_value_out = s.max_val;

endmodule : fpmc_front_panel

// *** verilog/fpmc_pkg.sv ***
/*
  Shared constants and types of the front-panel menu controller: key timing,
  display ranges, menu items and parameter limits.
  Assumes a 250 MHz system clock; all cycle counts derive from it.
*/
package fpmc_pkg;

  // Clock rate, Hz (250 MHz)
  localparam longint unsigned CLK_HZ = 64'h0000_0000_0EE6_B280;
  localparam longint unsigned MS_PER_S = 64'h0000_0000_0000_03E8;

  // Times in their own units
  localparam longint unsigned LAMP_MS = 64'h0000_0000_0000_03E8;     // 1000 ms
  localparam longint unsigned LONG_MS = 64'h0000_0000_0000_07D0;     // 2000 ms
  localparam longint unsigned DEBOUNCE_MS = 64'h0000_0000_0000_0014; // 20 ms
  localparam longint unsigned REPEAT_MS = 64'h0000_0000_0000_0064;   // 100 ms
  localparam longint unsigned BLINK_MS = 64'h0000_0000_0000_01F4;    // 500 ms
  localparam longint unsigned IDLE_S = 64'h0000_0000_0000_001E;      // 30 s
  localparam longint unsigned SIM_IDLE_S = 64'h0000_0000_0000_0384;  // 15 min

  // Cycle counts; least times round up, longest times round down
  localparam longint unsigned LAMP_CYC = (LAMP_MS * CLK_HZ) / MS_PER_S;
  localparam longint unsigned LONG_CYC = (LONG_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
  localparam longint unsigned DEBOUNCE_CYC = (DEBOUNCE_MS * CLK_HZ + MS_PER_S - 1) / MS_PER_S;
  localparam longint unsigned REPEAT_CYC = (REPEAT_MS * CLK_HZ) / MS_PER_S;
  localparam longint unsigned BLINK_CYC = (BLINK_MS * CLK_HZ) / MS_PER_S;
  localparam longint unsigned IDLE_CYC = IDLE_S * CLK_HZ;
  localparam longint unsigned SIM_IDLE_CYC = SIM_IDLE_S * CLK_HZ;

  // Temperatures are signed tenths of a degree
  localparam int VAL_W = 15;
  localparam logic signed [14:0] TEMP_MIN = -15'sh07C6;   // -199.0
  localparam logic signed [14:0] TEMP_MAX = 15'sh2134;    // +850.0
  localparam logic signed [14:0] FINE_MIN = -15'sh00C7;   // -19.9
  localparam logic signed [14:0] FINE_MAX = 15'sh03E7;    // 99.9
  localparam logic signed [14:0] TENTHS_DIV = 15'sh000A;

  // Sensor types: resistance types first, thermocouples after
  localparam logic signed [14:0] SENSOR_LAST = 15'sh000C;
  localparam logic [3:0] RES_TYPES = 4'h4;
  // Line resistance in tenths of ohm; top code means three-wire
  localparam logic signed [14:0] LINE_3WIRE = 15'sh03E8;
  localparam logic [9:0] LINE_3WIRE_U = 10'h3E8;
  // Simulated output select: 0..3 single outputs, 4 all together
  localparam logic signed [14:0] SIM_SEL_LAST = 15'sh0004;
  localparam logic signed [14:0] ZERO = 15'sh0000;

  typedef enum logic [1:0]
  {
    MODE_LAMP = 2'b00,
    MODE_DISPLAY = 2'b01,
    MODE_MENU = 2'b10,
    MODE_PARAM = 2'b11
  } fpmc_mode_type;

  typedef enum logic [1:0]
  {
    MENU_INPUT = 2'b00,
    MENU_SIM = 2'b01
  } fpmc_menu_type;

  localparam fpmc_menu_type MENU_FIRST = MENU_INPUT;
  localparam fpmc_menu_type MENU_LAST = MENU_SIM;

  typedef enum logic [1:0]
  {
    SHOW_LIVE = 2'b00,
    SHOW_MAX = 2'b01,
    SHOW_MIN = 2'b10
  } fpmc_show_type;

  typedef enum logic [1:0]
  {
    KIND_LAMP = 2'b00,
    KIND_VALUE = 2'b01,
    KIND_MENU = 2'b10,
    KIND_PARAM = 2'b11
  } fpmc_kind_type;

endpackage : fpmc_pkg

// *** verilog/fpmc_key.sv ***
/*
  One front-panel key: two-stage synchroniser, debounce, and press
  classification into press, short release, long hold and repeat pulses.
  Assumes an active-low key pin from outside the clock domain.
*/
`timescale 1ns/1ns
module fpmc_key #(
  parameter int unsigned DEBOUNCE_CYCLES = 32'h0000_0001,
  parameter int unsigned LONG_CYCLES = 32'h0000_0002,
  parameter int unsigned REPEAT_CYCLES = 32'h0000_0001
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  // Key pin
  input wire logic key_n_in,
  // Classified events
  output logic held_out,
  output logic press_out,
  output logic short_out,
  output logic long_out,
  output logic repeat_out
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic held;
    logic [31:0] deb_cnt;
    logic [31:0] hold_cnt;
    logic [31:0] rep_cnt;
    logic long_seen;
    logic press;
    logic short_rel;
    logic long_hit;
    logic rep;
  } fpmc_key_state_type;

  fpmc_key_state_type s;
  fpmc_key_state_type next_s;

  always_comb
  begin
    next_s = s;
    next_s.sync1 = ~key_n_in;
    next_s.sync2 = s.sync1;
    next_s.press = 1'b0;
    next_s.short_rel = 1'b0;
    next_s.long_hit = 1'b0;
    next_s.rep = 1'b0;
    // Level must stay changed for the whole debounce time
    if (s.sync2 == s.held)
    begin
      next_s.deb_cnt = '0;
    end
    else if (s.deb_cnt >= DEBOUNCE_CYCLES - 1)
    begin
      next_s.deb_cnt = '0;
      next_s.held = s.sync2;
      next_s.press = s.sync2;
      next_s.short_rel = ~s.sync2 & ~s.long_seen;
    end
    else
    begin
      next_s.deb_cnt = s.deb_cnt + 32'h0000_0001;
    end
    if (!s.held)
    begin
      next_s.hold_cnt = '0;
      next_s.rep_cnt = '0;
      next_s.long_seen = 1'b0;
    end
    else if (!s.long_seen)
    begin
      next_s.hold_cnt = s.hold_cnt + 32'h0000_0001;
      if (s.hold_cnt >= LONG_CYCLES - 1)
      begin
        next_s.long_seen = 1'b1;
        next_s.long_hit = 1'b1;
      end
    end
    else if (s.rep_cnt >= REPEAT_CYCLES - 1)
    begin
      next_s.rep_cnt = '0;
      next_s.rep = 1'b1;
    end
    else
    begin
      next_s.rep_cnt = s.rep_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s <= '0;
    end
    else if (clk_en_in)
    begin
      s <= next_s;
    end
  end

  assign held_out = s.held;
  assign press_out = s.press;
  assign short_out = s.short_rel;
  assign long_out = s.long_hit;
  assign repeat_out = s.rep;

endmodule : fpmc_key

// *** testbench/fpmc_chk.sv ***
/*
  Checker of the front-panel controller's outputs.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module fpmc_chk (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Observed outputs
  input wire logic lamp_test_out,
  input wire logic ready_out,
  input wire logic dp_last_out,
  input wire logic [1:0] mode_out,
  input wire logic [1:0] disp_kind_out,
  input wire logic signed [14:0] disp_value_out,
  input wire logic disp_tenths_out,
  input wire logic [3:0] sensor_type_out,
  input wire logic [9:0] line_res_out,
  input wire logic three_wire_out,
  input wire logic signed [14:0] min_value_out,
  input wire logic signed [14:0] max_value_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  ready_inverse_a: assert property (ready_out == !lamp_test_out)
    else $error("ready is not the inverse of lamp test");
  lamp_mode_a: assert property (lamp_test_out == (mode_out == 2'h0))
    else $error("lamp test and lamp mode disagree");
  display_dark_a: assert property (mode_out == 2'h1 |-> !dp_last_out)
    else $error("point lit in display mode");
  menu_lit_a: assert property (mode_out == 2'h2 |-> dp_last_out)
    else $error("point dark in menu mode");
  param_blink_a: assert property (not ((mode_out == 2'h3 && $stable(dp_last_out)) [*8]))
    else $error("point not blinking in parameter mode");
  three_wire_a: assert property (three_wire_out == (line_res_out == 10'h3E8))
    else $error("three-wire flag wrong");
  line_limit_a: assert property (line_res_out <= fpmc_pkg::LINE_3WIRE_U)
    else $error("line resistance out of range");
  sensor_limit_a: assert property (sensor_type_out <= 4'hC)
    else $error("sensor type out of range");
  record_order_a: assert property (min_value_out <= max_value_out &&
    max_value_out <= fpmc_pkg::TEMP_MAX && min_value_out >= fpmc_pkg::TEMP_MIN)
    else $error("min or max record out of order");
  fine_range_a: assert property (disp_kind_out == 2'h1 && disp_tenths_out |->
    disp_value_out >= fpmc_pkg::FINE_MIN && disp_value_out <= fpmc_pkg::FINE_MAX)
    else $error("tenths shown outside fine range");
  param_c: cover property (mode_out == 2'h3);
  two_wire_c: cover property ($fell(three_wire_out));
  tenths_c: cover property (disp_kind_out == 2'h1 && disp_tenths_out);
endmodule : fpmc_chk

// *** testbench/fpmc_operator.sv ***
/*
  Operator model: presses keys with a short contact bounce on each change.
  Assumes key pins are active low with pull-ups.
*/
`timescale 1ns/1ns
module fpmc_operator (
  // Clock
  input wire logic sys_clk_in,
  // Keys, bit 0 up, 1 down, 2 set, low while pressed
  output logic [2:0] keys_n_out
);
  initial keys_n_out = 3'h7;
  // Bounce lasts one cycle, below the filter length
  task automatic hold(input logic [2:0] mask);
    logic [2:0] prev;
    prev = keys_n_out;
    @(negedge sys_clk_in);
    keys_n_out = ~mask;
    @(negedge sys_clk_in);
    keys_n_out = prev;
    @(negedge sys_clk_in);
    keys_n_out = ~mask;
  endtask : hold
  task automatic press(input logic [2:0] mask, input int cycles);
    hold(mask);
    repeat (cycles) @(negedge sys_clk_in);
    hold(3'h0);
    repeat (12) @(negedge sys_clk_in);
  endtask : press
endmodule : fpmc_operator

// *** testbench/fpmc_front_panel_test.sv ***
/*
  Self-checking bench of the front-panel controller with shortened counts.
  Assumes the operator model drives the keys; clock enable is low for ten cycles of the lamp test, high otherwise.
*/
`timescale 1ns/1ns
module fpmc_front_panel_test;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic signed [14:0] temp_value_in = '0;
  logic temp_valid_in = 1'b0;
  logic [2:0] k, sim_select_out;
  logic lamp_test_out, ready_out, three_wire_out, param_index_out, disp_tenths_out, dp_last_out;
  logic [1:0] mode_out, menu_item_out, disp_kind_out;
  logic [3:0] sensor_type_out;
  logic [9:0] line_res_out;
  logic signed [14:0] disp_value_out, min_value_out, max_value_out, sim_temp_out;
  int num_errors = 0;
  int checks_done = 0;
  initial forever #2 sys_clk_in = ~sys_clk_in;
  fpmc_operator u_op (.sys_clk_in, .keys_n_out(k));
  localparam int unsigned T_LAMP = 32'h14, T_LONG = 32'h28, T_DEB = 32'h3, T_REP = 32'h5;
  localparam int unsigned T_BLINK = 32'h4;
  localparam logic [39:0] T_IDLE = 40'hC8, T_SIM_IDLE = 40'h190;
  fpmc_front_panel #(.LAMP_CYCLES(T_LAMP), .LONG_CYCLES(T_LONG), .DEBOUNCE_CYCLES(T_DEB),
    .REPEAT_CYCLES(T_REP), .BLINK_CYCLES(T_BLINK), .IDLE_CYCLES(T_IDLE),
    .SIM_IDLE_CYCLES(T_SIM_IDLE)) u_dut (.sys_clk_in, .reset_n_in, .clk_en_in,
    .key_up_n_in(k[0]), .key_down_n_in(k[1]), .key_set_n_in(k[2]), .temp_value_in,
    .temp_valid_in, .lamp_test_out, .ready_out, .dp_last_out, .disp_kind_out,
    .disp_value_out, .disp_tenths_out, .mode_out, .menu_item_out, .param_index_out,
    .sensor_type_out, .line_res_out, .three_wire_out, .sim_select_out, .sim_temp_out,
    .min_value_out, .max_value_out);
  task automatic chk(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic t_lamp();
    int n;
    n = 0;
    repeat (12) @(negedge sys_clk_in);
    chk(lamp_test_out === 1'b1 && three_wire_out === 1'b1, "reset state");
    reset_n_in = 1'b1;
    // Ten frozen cycles must stretch the lamp test to 29 to 32 cycles in all
    clk_en_in = 1'b0;
    while (ready_out !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk_in);
      n++;
      if (n == 10)
        clk_en_in = 1'b1;
    end
    chk(n >= 29 && n <= 32 && mode_out === 2'h1, "lamp length");
    if (n >= 100)
      stop_test();
    $display("lamp test done");
  endtask : t_lamp
  task automatic sample(input logic signed [14:0] v);
    @(negedge sys_clk_in);
    temp_value_in = v;
    temp_valid_in = 1'b1;
    @(negedge sys_clk_in);
    temp_valid_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
  endtask : sample
  task automatic t_minmax();
    sample(15'sh0064);
    sample(-15'sh0032);
    sample(15'sh2328);
    chk(min_value_out === -15'sh0032 && max_value_out === 15'sh2134, "records");
    chk(disp_tenths_out === 1'b0 && disp_value_out === 15'sh0352, "whole degrees");
    sample(15'sh01F9);
    chk(disp_tenths_out === 1'b1 && disp_value_out === 15'sh01F9, "tenths");
    u_op.hold(3'h1);
    repeat (50) @(negedge sys_clk_in);
    chk(disp_value_out === 15'sh0352, "max shown");
    u_op.hold(3'h5);
    repeat (50) @(negedge sys_clk_in);
    chk(max_value_out === 15'sh01F9, "max cleared");
    u_op.press(3'h0, 0);
    $display("min max test done");
  endtask : t_minmax
  task automatic t_input();
    u_op.press(3'h2, 8);
    chk(mode_out === 2'h2 && menu_item_out === 2'h0, "input item");
    u_op.press(3'h4, 8);
    chk(mode_out === 2'h3 && param_index_out === 1'b0, "param entry");
    u_op.press(3'h1, 8);
    u_op.press(3'h4, 8);
    chk(sensor_type_out === 4'h1 && param_index_out === 1'b1, "type stored");
    u_op.hold(3'h1);
    u_op.hold(3'h3);
    repeat (12) @(negedge sys_clk_in);
    u_op.press(3'h0, 0);
    u_op.press(3'h4, 8);
    chk(line_res_out === 10'h000 && mode_out === 2'h2, "zeroed line");
    u_op.press(3'h1, 8);
    chk(mode_out === 2'h1, "back to display");
    $display("input test done");
  endtask : t_input
  task automatic t_thermo();
    u_op.press(3'h2, 8);
    u_op.press(3'h4, 8);
    u_op.press(3'h1, 80);
    u_op.press(3'h4, 8);
    chk(sensor_type_out >= 4'h4 && mode_out === 2'h2, "fast steps, no line");
    u_op.press(3'h1, 8);
    $display("thermocouple test done");
  endtask : t_thermo
  task automatic t_long();
    logic [3:0] s;
    s = sensor_type_out;
    u_op.press(3'h2, 8);
    u_op.press(3'h4, 8);
    u_op.press(3'h2, 8);
    u_op.press(3'h4, 50);
    chk(mode_out === 2'h1 && sensor_type_out === s - 4'h1, "long set");
    u_op.press(3'h2, 8);
    u_op.press(3'h4, 8);
    u_op.press(3'h1, 8);
    repeat (150) @(negedge sys_clk_in);
    chk(mode_out === 2'h3, "early timeout");
    repeat (100) @(negedge sys_clk_in);
    chk(mode_out === 2'h1 && sensor_type_out === s - 4'h1, "timeout");
    $display("long set and timeout test done");
  endtask : t_long
  task automatic t_sim();
    u_op.press(3'h1, 8);
    u_op.press(3'h4, 8);
    u_op.press(3'h1, 8);
    u_op.press(3'h4, 8);
    u_op.press(3'h2, 8);
    u_op.press(3'h4, 50);
    chk(mode_out === 2'h3 && sim_temp_out === 15'sh0000, "long set in simulation");
    u_op.press(3'h4, 8);
    chk(sim_select_out === 3'h1 && sim_temp_out === -15'sh0001, "sim stored");
    u_op.press(3'h2, 8);
    chk(mode_out === 2'h1, "sim item to display");
    $display("simulation test done");
  endtask : t_sim
  initial
  begin
    t_lamp();
    t_minmax();
    t_input();
    t_thermo();
    t_long();
    t_sim();
    stop_test();
  end
endmodule : fpmc_front_panel_test
bind fpmc_front_panel fpmc_chk u_chk (.sys_clk_in, .reset_n_in, .lamp_test_out, .ready_out,
  .dp_last_out, .mode_out, .disp_kind_out, .disp_value_out, .disp_tenths_out,
  .sensor_type_out, .line_res_out, .three_wire_out, .min_value_out, .max_value_out);
